// File: crqic_pkg.sv
package crqic_pkg;

   // -----------------------------------------------------------------
   // bus address and register map
   // -----------------------------------------------------------------
   localparam logic [6:0] I2C_ADDR      = 7'h38;
   localparam logic [7:0] REG_CFG       = 8'h00;
   localparam logic [7:0] REG_OUT1      = 8'h01;
   localparam logic [7:0] REG_STATUS    = 8'h05;

   // -----------------------------------------------------------------
   // reset values and writable-bit masks
   // -----------------------------------------------------------------
   localparam logic [7:0] CFG_RESET     = 8'h44;
   localparam logic [7:0] OUT_RESET     = 8'h06;
   localparam logic [7:0] CFG_MASK      = 8'h7f;
   localparam logic [7:0] OUT_MASK      = 8'h3f;
   localparam logic [7:0] STAT_MASK     = 8'h01;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CFG_OUT_MODE  = 0;
   localparam int CFG_REQ_OD    = 1;
   localparam int CFG_REQ_POL   = 2;
   localparam int CFG_REQ_FORCE = 3;
   localparam int CFG_IN_DC     = 4;
   localparam int CFG_LDO_LO    = 5;
   localparam int CFG_LDO_HI    = 6;
   localparam int OUT_LOAD_LO   = 0;
   localparam int OUT_LOAD_HI   = 1;
   localparam int OUT_POL       = 2;
   localparam int OUT_FON       = 3;
   localparam int OUT_FOFF      = 4;
   localparam int OUT_PD        = 5;
   localparam int STAT_OT       = 0;

   // -----------------------------------------------------------------
   // regulator modes and byte framing
   // -----------------------------------------------------------------
   localparam logic [1:0] LDO_OFF       = 2'b00;
   localparam logic [1:0] LDO_RSVD      = 2'b01;
   localparam logic [1:0] LDO_TRACK     = 2'b10;
   localparam logic [1:0] LDO_ON        = 2'b11;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_BIT      = 4'h7;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_ADDR  = 4'h1,
      ST_AACK  = 4'h3,
      ST_REG   = 4'h2,
      ST_RACK  = 4'h6,
      ST_WDATA = 4'h7,
      ST_WACK  = 4'h5,
      ST_TX    = 4'h4,
      ST_MACK  = 4'hc
   } crqic_state_t;

endpackage

// File: crqic_top.sv
`timescale 1ns/1ps
// Function
// R1: one request per output gates it
// R2: each request input has selectable polarity
// R3: outputs enabled at source clock falling edge
// R4: source request asserted when any request active
// R5: force bit holds source request asserted
// R6: source request polarity and drive type configurable
// R7: power-up loads defaults, settings then retained
// R8: tracking mode regulator follows any request
// R9: regulator can be forced permanently on
// R10: overtemperature shuts down, sets readable status
// R11: bus target address is 38h
// R12: data changes only while clock low
// R13: start and stop detected with clock high
// R14: master generates start, stop, repeated start
// R15: busy start to stop, repeated start same
// R16: eight bits msb first then acknowledge
// R17: receiver pulls data low on ninth clock
// R18: first byte address plus direction bit
// R19: write: register byte then data byte
// R20: write applied at final acknowledge rising clock
// R21: master sets pointer by write before read
// R22: regulator mode 00 off 10 track 11 on
// R23: force-off beats force-on per output
// R24: foreign address leaves data released, ignored
module crqic_top #(
   parameter int N_OUT = 4
) (
   // system
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   // source clock and gated outputs
   input  wire logic               sclk_in,
   output      logic [N_OUT-1:0]   clk_out,
   // peripheral requests and regulator thermal flag
   input  wire logic [N_OUT-1:0]   req_in,
   input  wire logic               ldo_overtemp,
   // two-wire bus
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   output      logic               sda_o,
   output      logic               sda_oe,
   // source clock request pin
   output      logic               sclk_req_o,
   output      logic               sclk_req_oe,
   // regulator and analog settings
   output      logic               ldo_en,
   output      logic               output_mode,
   output      logic               clk_in_dc,
   output      logic [2*N_OUT-1:0] drive_load,
   output      logic [N_OUT-1:0]   req_pulldown,
   output      logic               overtemp_flag
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic                      scl_s1;
      logic                      scl_s2;
      logic                      scl_d;
      logic                      sda_s1;
      logic                      sda_s2;
      logic                      sda_d;
      logic [N_OUT-1:0]          req_s1;
      logic [N_OUT-1:0]          req_s2;
      logic                      ot_s1;
      logic                      ot_s2;
      crqic_pkg::crqic_state_t   state;
      logic [3:0]                cnt;
      logic [7:0]                sr;
      logic                      rnw;
      logic                      mack;
      logic [7:0]                ptr;
      logic                      sda_oe;
      logic [7:0]                cfg;
      logic [N_OUT-1:0][7:0]     outr;
      logic                      ot_flag;
      logic                      sreq_out;
      logic                      sreq_oe;
      logic                      ldo_en;
      logic [N_OUT-1:0]          en;
   } crqic_state_s_t;

   typedef struct packed {
      logic [N_OUT-1:0] g1;
      logic [N_OUT-1:0] g2;
   } crqic_link_t;

   crqic_state_s_t st_r;
   crqic_state_s_t st_nxt;
   crqic_link_t    lk_r;
   crqic_link_t    lk_nxt;

   logic             scl_rise;
   logic             scl_fall;
   logic             bus_start;
   logic             bus_stop;
   logic [N_OUT-1:0] act_c;
   logic [N_OUT-1:0] foff_c;
   logic             any_c;
   logic             sdn_c;
   logic [7:0]       rd_c;

   assign scl_rise  = st_r.scl_s2 & ~st_r.scl_d;
   assign scl_fall  = ~st_r.scl_s2 & st_r.scl_d;
   // see R13
   assign bus_start = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_s2 & st_r.sda_d;
   assign bus_stop  = st_r.scl_s2 & st_r.scl_d & st_r.sda_s2 & ~st_r.sda_d;

   // -----------------------------------------------------------------
   // request decode and register read mux
   // -----------------------------------------------------------------
   always_comb
   begin
      rd_c = 8'h00;
      for (int i = 0; i < N_OUT; i++)
      begin
         // see R2
         act_c[i]  = st_r.req_s2[i] == st_r.outr[i][crqic_pkg::OUT_POL];
         foff_c[i] = st_r.outr[i][crqic_pkg::OUT_FOFF];
         if (st_r.ptr == crqic_pkg::REG_OUT1 + 8'(i))
            rd_c = st_r.outr[i];
      end
      if (st_r.ptr == crqic_pkg::REG_CFG)
         rd_c = st_r.cfg;
      else if (st_r.ptr == crqic_pkg::REG_STATUS)
         rd_c = {7'h00, st_r.ot_flag};
      any_c = |act_c;
      // see R10
      sdn_c = st_r.ot_s2 | st_r.ot_flag;
   end

   // -----------------------------------------------------------------
   // reference-domain next state
   // -----------------------------------------------------------------
   always_comb
   begin
      logic req_asserted;
      logic [7:0] wd;
      st_nxt = st_r;
      req_asserted = 1'b0;
      wd = st_r.sr;
      st_nxt.scl_s1 = scl_i;
      st_nxt.scl_s2 = st_r.scl_s1;
      st_nxt.scl_d  = st_r.scl_s2;
      st_nxt.sda_s1 = sda_i;
      st_nxt.sda_s2 = st_r.sda_s1;
      st_nxt.sda_d  = st_r.sda_s2;
      st_nxt.req_s1 = req_in;
      st_nxt.req_s2 = st_r.req_s1;
      st_nxt.ot_s1  = ldo_overtemp;
      st_nxt.ot_s2  = st_r.ot_s1;

      // gate requests; force-off wins over force-on
      for (int i = 0; i < N_OUT; i++)
         st_nxt.en[i] = ~sdn_c & ~st_r.outr[i][crqic_pkg::OUT_FOFF]   // see R23
                        & (st_r.outr[i][crqic_pkg::OUT_FON] | act_c[i]); // see R1

      // source clock request pin
      req_asserted = ~sdn_c & (any_c | st_r.cfg[crqic_pkg::CFG_REQ_FORCE]); // see R4 R5
      // see R6
      st_nxt.sreq_out = req_asserted ? st_r.cfg[crqic_pkg::CFG_REQ_POL]
                                     : ~st_r.cfg[crqic_pkg::CFG_REQ_POL];
      st_nxt.sreq_oe  = ~st_r.cfg[crqic_pkg::CFG_REQ_OD] | req_asserted;

      // regulator; the reserved code behaves as off
      unique case (st_r.cfg[crqic_pkg::CFG_LDO_HI:crqic_pkg::CFG_LDO_LO]) // see R22
         crqic_pkg::LDO_TRACK: st_nxt.ldo_en = ~sdn_c & any_c;         // see R8
         crqic_pkg::LDO_ON:    st_nxt.ldo_en = ~sdn_c;                 // see R9
         crqic_pkg::LDO_OFF,
         crqic_pkg::LDO_RSVD:  st_nxt.ldo_en = 1'b0;
      endcase

      // protocol engine
      if (bus_start)
      begin
         // a repeated start restarts the frame exactly like a first one
         st_nxt.state  = crqic_pkg::ST_ADDR; // see R15
         st_nxt.cnt    = 4'h0;
         st_nxt.sda_oe = 1'b0;
      end
      else if (bus_stop)
      begin
         st_nxt.state  = crqic_pkg::ST_IDLE; // see R15
         st_nxt.sda_oe = 1'b0;
      end
      else
      begin
         unique case (st_r.state)
            crqic_pkg::ST_IDLE: ;
            crqic_pkg::ST_ADDR,
            crqic_pkg::ST_REG,
            crqic_pkg::ST_WDATA:
            begin
               if (scl_rise)
               begin
                  st_nxt.sr  = {st_r.sr[6:0], st_r.sda_s2}; // see R16
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end
               else if (scl_fall && st_r.cnt == crqic_pkg::BITS_PER_BYTE)
               begin
                  st_nxt.sda_oe = 1'b1; // see R17
                  if (st_r.state == crqic_pkg::ST_ADDR)
                  begin
                     st_nxt.rnw = st_r.sr[0]; // see R18
                     if (st_r.sr[7:1] == crqic_pkg::I2C_ADDR) // see R11
                        st_nxt.state = crqic_pkg::ST_AACK;
                     else
                     begin
                        st_nxt.state  = crqic_pkg::ST_IDLE; // see R24
                        st_nxt.sda_oe = 1'b0;
                     end
                  end
                  else if (st_r.state == crqic_pkg::ST_REG)
                  begin
                     st_nxt.ptr   = st_r.sr; // see R19
                     st_nxt.state = crqic_pkg::ST_RACK;
                  end
                  else
                     st_nxt.state = crqic_pkg::ST_WACK;
               end
            end
            crqic_pkg::ST_AACK:
            begin
               if (scl_fall)
               begin
                  st_nxt.cnt = 4'h0;
                  if (st_r.rnw)
                  begin
                     // the pointer comes from an earlier write frame
                     st_nxt.state  = crqic_pkg::ST_TX; // see R21
                     st_nxt.sr     = rd_c;
                     st_nxt.sda_oe = ~rd_c[7];
                     st_nxt.ptr    = st_r.ptr + 8'h01;
                  end
                  else
                  begin
                     st_nxt.state  = crqic_pkg::ST_REG;
                     st_nxt.sda_oe = 1'b0;
                  end
               end
            end
            crqic_pkg::ST_RACK:
            begin
               if (scl_fall)
               begin
                  st_nxt.state  = crqic_pkg::ST_WDATA;
                  st_nxt.cnt    = 4'h0;
                  st_nxt.sda_oe = 1'b0;
               end
            end
            crqic_pkg::ST_WACK:
            begin
               if (scl_rise)
               begin
                  // see R20
                  if (st_r.ptr == crqic_pkg::REG_CFG)
                     st_nxt.cfg = wd & crqic_pkg::CFG_MASK;
                  for (int i = 0; i < N_OUT; i++)
                     if (st_r.ptr == crqic_pkg::REG_OUT1 + 8'(i))
                        st_nxt.outr[i] = wd & crqic_pkg::OUT_MASK;
               end
               else if (scl_fall)
               begin
                  st_nxt.state  = crqic_pkg::ST_WDATA;
                  st_nxt.cnt    = 4'h0;
                  st_nxt.sda_oe = 1'b0;
                  st_nxt.ptr    = st_r.ptr + 8'h01;
               end
            end
            crqic_pkg::ST_TX:
            begin
               if (scl_fall)
               begin
                  if (st_r.cnt == crqic_pkg::LAST_BIT)
                  begin
                     st_nxt.state  = crqic_pkg::ST_MACK; // see R17
                     st_nxt.sda_oe = 1'b0;
                  end
                  else
                  begin
                     st_nxt.sr     = {st_r.sr[6:0], 1'b0};
                     st_nxt.sda_oe = ~st_r.sr[6]; // see R12
                     st_nxt.cnt    = st_r.cnt + 4'h1;
                  end
               end
            end
            crqic_pkg::ST_MACK:
            begin
               if (scl_rise)
                  st_nxt.mack = st_r.sda_s2;
               else if (scl_fall)
               begin
                  st_nxt.cnt = 4'h0;
                  if (!st_r.mack)
                  begin
                     st_nxt.state  = crqic_pkg::ST_TX;
                     st_nxt.sr     = rd_c;
                     st_nxt.sda_oe = ~rd_c[7];
                     st_nxt.ptr    = st_r.ptr + 8'h01;
                  end
                  else
                     st_nxt.state = crqic_pkg::ST_IDLE;
               end
            end
            default:
            begin
               st_nxt.state  = crqic_pkg::ST_IDLE;
               st_nxt.sda_oe = 1'b0;
            end
         endcase
      end

      // sticky status: a new event beats a clear written in the same cycle
      if (st_r.state == crqic_pkg::ST_WACK && scl_rise
          && st_r.ptr == crqic_pkg::REG_STATUS && wd[crqic_pkg::STAT_OT])
         st_nxt.ot_flag = 1'b0;
      if (st_r.ot_s2)
         st_nxt.ot_flag = 1'b1; // see R10
   end

   // registers hold their values until the next power-up reset
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r          <= '0;                        // see R7
         st_r.scl_s1   <= 1'b1;
         st_r.scl_s2   <= 1'b1;
         st_r.scl_d    <= 1'b1;
         st_r.sda_s1   <= 1'b1;
         st_r.sda_s2   <= 1'b1;
         st_r.sda_d    <= 1'b1;
         st_r.state    <= crqic_pkg::ST_IDLE;
         st_r.cfg      <= crqic_pkg::CFG_RESET;
         st_r.outr     <= {N_OUT{crqic_pkg::OUT_RESET}};
         st_r.sreq_out <= ~crqic_pkg::CFG_RESET[crqic_pkg::CFG_REQ_POL];
         st_r.sreq_oe  <= ~crqic_pkg::CFG_RESET[crqic_pkg::CFG_REQ_OD];
      end
      else
         st_r <= st_nxt;
   end

   // -----------------------------------------------------------------
   // source clock domain: glitch-free output gates
   // -----------------------------------------------------------------
   // gates move only while the source clock is low, so no runt pulse
   always_comb
   begin
      lk_nxt    = lk_r;
      lk_nxt.g1 = st_r.en;
      lk_nxt.g2 = lk_r.g1;
   end

   always_ff @(negedge sclk_in or negedge rst_n)
   begin
      if (!rst_n)
         lk_r <= '0;
      else
         lk_r <= lk_nxt; // see R3
   end

   assign clk_out = {N_OUT{sclk_in}} & lk_r.g2; // see R1 R3

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign sda_o         = 1'b0;
   assign sda_oe        = st_r.sda_oe;
   assign sclk_req_o    = st_r.sreq_out;
   assign sclk_req_oe   = st_r.sreq_oe;
   assign ldo_en        = st_r.ldo_en;
   assign output_mode   = st_r.cfg[crqic_pkg::CFG_OUT_MODE];
   assign clk_in_dc     = st_r.cfg[crqic_pkg::CFG_IN_DC];
   assign overtemp_flag = st_r.ot_flag;
   always_comb
   begin
      for (int i = 0; i < N_OUT; i++)
      begin
         drive_load[2*i +: 2] = st_r.outr[i][crqic_pkg::OUT_LOAD_HI:crqic_pkg::OUT_LOAD_LO];
         req_pulldown[i]      = st_r.outr[i][crqic_pkg::OUT_PD];
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   property p_force_off;
      @(posedge ref_clk) disable iff (!rst_n)
      (st_r.en & $past(foff_c)) == '0;
   endproperty
   a_force_off: assert property (p_force_off) else $error("gate on under force-off"); // see R23

   property p_req_out;
      @(posedge ref_clk) disable iff (!rst_n)
      $past(any_c) && !$past(sdn_c)
      |-> st_r.sreq_out == $past(st_r.cfg[crqic_pkg::CFG_REQ_POL]);
   endproperty
   a_req_out: assert property (p_req_out) else $error("source request not asserted"); // see R4

   property p_req_force;
      @(posedge ref_clk) disable iff (!rst_n)
      st_r.cfg[crqic_pkg::CFG_REQ_FORCE] && !sdn_c
      |=> st_r.sreq_out == $past(st_r.cfg[crqic_pkg::CFG_REQ_POL]);
   endproperty
   a_req_force: assert property (p_req_force) else $error("forced request missing"); // see R5

   property p_pushpull;
      @(posedge ref_clk) disable iff (!rst_n)
      !st_r.cfg[crqic_pkg::CFG_REQ_OD] |=> st_r.sreq_oe;
   endproperty
   a_pushpull: assert property (p_pushpull) else $error("push-pull pin released"); // see R6

   property p_ldo_track;
      @(posedge ref_clk) disable iff (!rst_n)
      st_r.cfg[crqic_pkg::CFG_LDO_HI:crqic_pkg::CFG_LDO_LO] == crqic_pkg::LDO_TRACK
      |=> st_r.ldo_en == ($past(any_c) && !$past(sdn_c));
   endproperty
   a_ldo_track: assert property (p_ldo_track) else $error("regulator not tracking"); // see R8

   property p_ldo_on;
      @(posedge ref_clk) disable iff (!rst_n)
      st_r.cfg[crqic_pkg::CFG_LDO_HI:crqic_pkg::CFG_LDO_LO] == crqic_pkg::LDO_ON && !sdn_c
      |=> st_r.ldo_en;
   endproperty
   a_ldo_on: assert property (p_ldo_on) else $error("regulator not forced on"); // see R9

   property p_overtemp;
      @(posedge ref_clk) disable iff (!rst_n)
      st_r.ot_s2 |=> st_r.ot_flag && !st_r.ldo_en && st_r.en == '0;
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("overtemperature not handled"); // see R10

   property p_foreign;
      @(posedge ref_clk) disable iff (!rst_n)
      st_r.state == crqic_pkg::ST_ADDR && scl_fall && !bus_start && !bus_stop
      && st_r.cnt == crqic_pkg::BITS_PER_BYTE && st_r.sr[7:1] != crqic_pkg::I2C_ADDR
      |=> st_r.state == crqic_pkg::ST_IDLE && !st_r.sda_oe;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address answered"); // see R24

   property p_start;
      @(posedge ref_clk) disable iff (!rst_n)
      bus_start |=> st_r.state == crqic_pkg::ST_ADDR && st_r.cnt == 4'h0 && !st_r.sda_oe;
   endproperty
   a_start: assert property (p_start) else $error("start not taken"); // see R15

   property p_sda_low_scl;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(st_r.sda_oe) |-> !st_r.scl_s2;
   endproperty
   a_sda_low_scl: assert property (p_sda_low_scl) else $error("data driven with clock high"); // see R12

   // gate flops may only move in the low phase of the source clock
   property p_gate_stable;
      @(posedge ref_clk) disable iff (!rst_n)
      sclk_in && $past(sclk_in) |-> $stable(lk_r.g2);
   endproperty
   a_gate_stable: assert property (p_gate_stable) else $error("gate moved while clock high"); // see R3

endmodule // crqic_top

// File: crqic_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// two-wire bus master
// ---------------------------------------------
module crqic_host_model (
   // two-wire bus
   output logic       scl,
   output logic       sda_m,
   input  wire logic  sda,
   // frame result: every byte refused, some byte refused
   output logic [1:0] na
);
   localparam time Q = 625ns;
   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
      na = 2'b00;
   end
   // data moves only in the low phase so no false start or stop is seen
   task automatic bitx(input logic b, output logic v);
      #Q sda_m = b;
      #Q scl = 1'b1;
      #Q v = sda;
      #Q scl = 1'b0;
   endtask
   task automatic start();
      #Q sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q sda_m = 1'b0;
      #Q scl = 1'b0;
   endtask
   task automatic stop();
      #Q sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #Q;
   endtask
   task automatic bytex(input logic [7:0] d, input logic mack, output logic [7:0] q);
      logic ak;
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(mack, ak);
      na = {na[1] & ak, na[0] | ak};
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] r0, input logic [31:0] d,
                     input int n);
      logic [7:0] q;
      start();
      na = 2'b10;
      bytex({a, 1'b0}, 1'b1, q);
      bytex(r0, 1'b1, q);
      for (int k = 0; k < n; k++) bytex(d[31-8*k -: 8], 1'b1, q);
      stop();
   endtask
   // pointer frame first, then a fresh start for the read
   task automatic rd(input logic [7:0] r0, output logic [7:0] v);
      logic [1:0] s;
      wr(7'h38, r0, 32'h0, 0);
      start();
      bytex(8'h71, 1'b1, v);
      s = na;
      bytex(8'hff, 1'b1, v);
      na = s;
      stop();
   endtask
endmodule // crqic_host_model

// File: testbench.sv
`timescale 1ns/1ps
// ---------------------------------------------
// design, bus master and reference model
// ---------------------------------------------
module testbench;
   logic        ref_clk, rst_n, sclk_in, ldo_overtemp, ot, scl, sda_m;
   logic [3:0]  req_in, clk_out, req_pulldown;
   logic [7:0]  drive_load, q;
   logic [7:0]  m [0:5];
   logic [1:0]  na;
   logic [31:0] seed;
   logic        sda_o, sda_oe, sclk_req_o, sclk_req_oe, ldo_en, output_mode, clk_in_dc;
   logic        overtemp_flag;
   int          n_errors, n_checks;
   // pull-up: low while either side pulls
   wire         sda = sda_m & (sda_oe ? sda_o : 1'b1);

   crqic_top #(.N_OUT(4)) crqic_top_inst (
      .ref_clk, .rst_n, .sclk_in, .clk_out, .req_in, .ldo_overtemp, .scl_i(scl), .sda_i(sda),
      .sda_o, .sda_oe, .sclk_req_o, .sclk_req_oe, .ldo_en, .output_mode, .clk_in_dc,
      .drive_load, .req_pulldown, .overtemp_flag
   );
   crqic_host_model host_inst (.scl, .sda_m, .sda, .na);

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // odd offset keeps the source clock out of step with ref_clk
   initial
   begin
      sclk_in = 1'b0;
      #13.7;
      forever #80 sclk_in = ~sclk_in;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      if (n_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // sampled in the high phase of the source clock, where a gated output is high
   task automatic outs(input logic [3:0] r);
      logic [3:0] act, g;
      logic       sh, as;
      @(posedge ref_clk) req_in <= r;
      repeat (4) @(posedge sclk_in);
      #20;
      for (int i = 0; i < 4; i++)
      begin
         act[i] = r[i] == m[i+1][2];
         g[i] = !m[i+1][4] && (m[i+1][3] || act[i]);
      end
      sh = ot | ldo_overtemp;
      as = !sh && (m[0][3] || |act);
      chk(clk_out, sh ? 4'h0 : g);
      chk(sclk_req_o, as ? m[0][2] : !m[0][2]);
      chk(sclk_req_oe, !m[0][1] || as);
      chk(ldo_en, !sh && (m[0][6:5] == 2'b11 || (m[0][6:5] == 2'b10 && |act)));
      chk({output_mode, clk_in_dc, req_pulldown},
          {m[0][0], m[0][4], m[4][5], m[3][5], m[2][5], m[1][5]});
      chk(drive_load, {m[4][1:0], m[3][1:0], m[2][1:0], m[1][1:0]});
      chk(overtemp_flag, ot);
   endtask
   task automatic rnd(input int n);
      repeat (n)
      begin
         seed = lfsr(seed);
         outs(seed[3:0]);
      end
   endtask
   task automatic w(input logic [7:0] r, input logic [31:0] d, input int n);
      logic [7:0] b;
      host_inst.wr(7'h38, r, d, n);
      chk(na, 2'b00);
      for (int k = 0; k < n; k++)
      begin
         b = d[31-8*k -: 8];
         if (r + k == 0) m[0] = b & 8'h7f;
         else if (r + k < 5) m[r+k] = b & 8'h3f;
         else if (r + k == 5 && b[0]) ot = 1'b0;
      end
   endtask

   initial
   begin
      rst_n = 1'b0;
      req_in = 4'h0;
      ldo_overtemp = 1'b0;
      ot = 1'b0;
      seed = 32'hf2a3b9a5;
      m[0] = 8'h44;
      for (int i = 1; i < 5; i++) m[i] = 8'h06;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rnd(6);
      outs(4'h0);
      host_inst.rd(8'h00, q);
      chk(q, m[0]);
      chk(na, 2'b00);
      w(8'h00, 32'h6a000000, 1);
      outs(4'h0);
      rnd(2);
      w(8'h00, 32'h02000000, 1);
      outs(4'h0);
      rnd(3);
      // low-active request, force-on, force-off with force-on
      w(8'h00, 32'h55210e1b, 4);
      rnd(6);
      host_inst.wr(7'h39, 8'h00, 32'h6a000000, 1);
      chk(na, 2'b11);
      rnd(2);
      @(posedge ref_clk) ldo_overtemp <= 1'b1;
      ot = 1'b1;
      rnd(2);
      @(posedge ref_clk) ldo_overtemp <= 1'b0;
      rnd(1);
      host_inst.rd(8'h05, q);
      chk(q, 8'h01);
      w(8'h05, 32'h01000000, 1);
      rnd(2);
      // reserved regulator code must behave as off
      w(8'h00, 32'h22000000, 1);
      rnd(3);
      stop_test();
   end
   initial
   begin
      // the whole test takes about 720 us; this limit stays under 100k clock cycles
      #780000;
      n_errors++;
      stop_test();
   end
endmodule // testbench
